// [include/hcm_pkg.sv]
// Constants, register map and carrier types of the heater modulation core
`default_nettype none
package hcm_pkg;
    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int SEC_S = 1;
    localparam int SEC_CYCLES = CLK_HZ * SEC_S;
    localparam int HOUR_S = 3600;
    localparam int FRAME_CYCLES = 10;
    localparam int SAMPLES_PER_FRAME = 300;
    // Widths and scaling
    localparam int ADC_W = 10;
    localparam int RAW_W = 12;
    localparam int LIN_SHIFT = 12;
    localparam int STEADY_TOL = 4;
    localparam logic [3:0] DUTY_FULL = 4'hA;
    localparam logic [3:0] DBF_MIN = 4'h1;
    localparam logic [3:0] DBF_MAX = 4'hA;
    localparam logic [3:0] DBF_RESET = 4'h5;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SETPOINT = 8'h04;
    localparam logic [7:0] OFS_DEADBAND = 8'h08;
    localparam logic [7:0] OFS_PLIMIT = 8'h0C;
    localparam logic [7:0] OFS_LIN_GAIN = 8'h10;
    localparam logic [7:0] OFS_LIN_OFFSET = 8'h14;
    localparam logic [7:0] OFS_LIN_CURVE = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_TEMP = 8'h20;
    localparam logic [7:0] OFS_MEAS_CUR = 8'h24;
    localparam logic [7:0] OFS_MEAS_GF = 8'h28;
    localparam logic [7:0] OFS_MEAS_VOLT = 8'h2C;
    localparam logic [7:0] OFS_I_FULL = 8'h30;
    localparam logic [7:0] OFS_HOUR_ERR = 8'h34;
    // Reset values
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [15:0] SETPOINT_RESET = 16'h0000;
    localparam logic [7:0] DEADBAND_RESET = 8'h00;
    localparam logic [9:0] PLIMIT_RESET = 10'h3FF;
    localparam logic [15:0] LIN_GAIN_RESET = 16'h1000;
    localparam logic [15:0] LIN_OFFSET_RESET = 16'h0000;
    localparam logic [15:0] LIN_CURVE_RESET = 16'h0000;
    // Control bit positions
    localparam int CTRL_PROP_BIT = 0;
    localparam int CTRL_PLIM_BIT = 1;
    localparam int CTRL_OVR_BIT = 2;
    localparam int CTRL_SPOFF_BIT = 3;

    typedef struct packed {
        logic [9:0] cur;
        logic [9:0] gf;
        logic [9:0] volt;
    } hcm_meas_t;

    typedef struct packed {
        logic setpoint_off;
        logic override_en;
        logic plimit_en;
        logic prop_en;
    } hcm_ctrl_t;
endpackage
`default_nettype wire

// [verilog/hcm_core.sv]
// Heater cycle modulation core with APB register slave
`default_nettype none
module hcm_core
    import hcm_pkg::*;
#(
    parameter int SEC_CYCLES_P = SEC_CYCLES,
    parameter int HOUR_SECONDS_P = HOUR_S
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic zero_cross_i,
    input wire logic override_closed_i,
    input wire logic adc_valid_i,
    input wire logic [1:0] adc_chan_i,
    input wire logic [ADC_W-1:0] adc_data_i,
    input wire logic temp_valid_i,
    input wire logic [RAW_W-1:0] temp_raw_i,
    output logic heater_gate_o
);
    localparam logic [3:0] FRAME_LAST = 4'(FRAME_CYCLES - 1);
    localparam logic [8:0] NSAMP = 9'(SAMPLES_PER_FRAME);
    localparam logic [23:0] SEC_LAST = 24'(SEC_CYCLES_P - 1);
    localparam logic [11:0] HOUR_LAST = 12'(HOUR_SECONDS_P - 1);

    hcm_ctrl_t ctrl_q;
    hcm_meas_t meas_q;
    logic signed [15:0] setpoint_q, offset_q, curve_q, temp_q;
    logic [15:0] gain_q, hour_err_q;
    logic [7:0] deadband_q;
    logic [9:0] plimit_q;
    logic zc_s1_q, zc_s2_q, zc_s3_q, ov_s1_q, ov_s2_q;
    logic zc_pulse, frame_end;
    logic [3:0] cyc_q, frame_duty_q, duty_q, meas_duty_q, prev_duty_q;
    logic [3:0] prop_duty_q, dbf_q;
    logic gate_q, demand_q, temp_new_q, meas_new_q, step_q, steady_q;
    logic dir_up_q, have_prev_q;
    logic [8:0] cnt_q [3];
    logic [18:0] sum_q [3];
    logic [9:0] prev_cur_q;
    logic [13:0] i_full_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    // Pin synchronisers; the edge detect compares the second and third stages
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            zc_s1_q <= 1'b0;
            zc_s2_q <= 1'b0;
            zc_s3_q <= 1'b0;
            ov_s1_q <= 1'b0;
            ov_s2_q <= 1'b0;
        end else begin
            zc_s1_q <= zero_cross_i;
            zc_s2_q <= zc_s1_q;
            zc_s3_q <= zc_s2_q;
            ov_s1_q <= override_closed_i;
            ov_s2_q <= ov_s1_q;
        end
    end

    assign zc_pulse = zc_s2_q & ~zc_s3_q;
    assign frame_end = zc_pulse && (cyc_q == FRAME_LAST);

    // Power-cycle index within the frame
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cyc_q <= 4'h0;
        end else if (zc_pulse) begin
            cyc_q <= (cyc_q == FRAME_LAST) ? 4'h0 : cyc_q + 4'h1;
        end
    end

    // Cycle k of a frame with n tenths conducts when the spread count steps
    function automatic logic cycle_on(input logic [3:0] n,
                                      input logic [3:0] k);
        logic [7:0] a;
        logic [7:0] b;
        a = ({4'h0, k} + 8'h01) * {4'h0, n};
        b = {4'h0, k} * {4'h0, n};
        return (a / 8'h0A) != (b / 8'h0A);
    endfunction

    // Override and setpoint-off decide whether control may run at all
    logic force_on, force_off;
    logic [3:0] target;
    assign force_on = ctrl_q.override_en & ov_s2_q & ctrl_q.setpoint_off;
    assign force_off = ~force_on & (ctrl_q.setpoint_off |
                       (ctrl_q.override_en & ~ov_s2_q));
    always_comb begin
        if (force_on) begin
            target = DUTY_FULL;
        end else if (force_off) begin
            target = 4'h0;
        end else if (ctrl_q.prop_en) begin
            target = prop_duty_q;
        end else begin
            target = demand_q ? DUTY_FULL : 4'h0;
        end
    end

    // Gate moves only on a crossing; new duty takes over at frame start
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gate_q <= 1'b0;
            frame_duty_q <= 4'h0;
        end else if (frame_end) begin
            frame_duty_q <= duty_q;
            gate_q <= cycle_on(duty_q, 4'h0) & ~force_off;
        end else if (zc_pulse) begin
            gate_q <= cycle_on(frame_duty_q, cyc_q + 4'h1) & ~force_off;
        end
    end
    assign heater_gate_o = gate_q;

    // Linearisation: gain, square-law curve and offset, then saturate
    logic [27:0] lin_p1;
    logic [23:0] lin_sq;
    logic signed [28:0] lin_p2;
    logic signed [17:0] lin_sum;
    logic signed [15:0] lin_t;
    assign lin_p1 = 28'(gain_q) * 28'(temp_raw_i);
    assign lin_sq = 24'(temp_raw_i) * 24'(temp_raw_i);
    assign lin_p2 = 29'(curve_q) * 29'($signed({1'b0, lin_sq[23:12]}));
    assign lin_sum = 18'($signed({1'b0, lin_p1[27:LIN_SHIFT]}))
                   + 18'(lin_p2 >>> LIN_SHIFT) + 18'(offset_q);
    always_comb begin
        if (lin_sum > 18'sh07FFF) begin
            lin_t = 16'sh7FFF;
        end else if (lin_sum < 18'sh38000) begin
            lin_t = 16'sh8000;
        end else begin
            lin_t = lin_sum[15:0];
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            temp_q <= 16'sh0000;
            temp_new_q <= 1'b0;
        end else begin
            temp_new_q <= temp_valid_i;
            if (temp_valid_i) begin
                temp_q <= lin_t;
            end
        end
    end

    // Error is setpoint minus temperature, one bit wider to avoid wrap
    logic signed [16:0] err, db_s;
    logic [16:0] abs_err;
    logic [3:0] prop_d;
    assign err = 17'(setpoint_q) - 17'(temp_q);
    assign db_s = $signed({9'h000, deadband_q});
    assign abs_err = err[16] ? 17'(-err) : 17'(err);
    always_comb begin
        if (err <= 17'sh00000) begin
            prop_d = 4'h0;
        end else if (err >= $signed({13'h0000, dbf_q})) begin
            prop_d = DUTY_FULL;
        end else begin
            prop_d = 4'((8'(err[3:0]) * 8'h0A) / {4'h0, dbf_q});
        end
    end

    // On/off demand with hysteresis, and proportional duty, per reading
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            demand_q <= 1'b0;
            prop_duty_q <= 4'h0;
        end else if (temp_new_q) begin
            prop_duty_q <= prop_d;
            if (deadband_q == 8'h00) begin
                if (err > 17'sh00000) begin
                    demand_q <= 1'b1;
                end else if (err < 17'sh00000) begin
                    demand_q <= 1'b0;
                end
            end else if (err >= db_s) begin
                demand_q <= 1'b1;
            end else if (err <= -db_s) begin
                demand_q <= 1'b0;
            end
        end
    end

    // Per-channel accumulation, restarted at every frame boundary
    // The sample on the boundary edge opens the new frame; dropping it
    // would leave one channel a sample short in every frame
    for (genvar c = 0; c < 3; c++) begin : g_acc
        logic take;
        assign take = adc_valid_i && (adc_chan_i == 2'(c));
        always_ff @(posedge mclk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                cnt_q[c] <= 9'h000;
                sum_q[c] <= 19'h00000;
            end else if (frame_end) begin
                cnt_q[c] <= take ? 9'h001 : 9'h000;
                sum_q[c] <= take ? 19'(adc_data_i) : 19'h00000;
            end else if (take && cnt_q[c] != NSAMP) begin
                cnt_q[c] <= cnt_q[c] + 9'h001;
                sum_q[c] <= sum_q[c] + 19'(adc_data_i);
            end
        end
    end

    // A frame counts only when every channel got its full sample set
    logic frame_full;
    assign frame_full = (cnt_q[0] == NSAMP) && (cnt_q[1] == NSAMP) &&
                        (cnt_q[2] == NSAMP);
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meas_q <= '0;
            meas_duty_q <= 4'h0;
            meas_new_q <= 1'b0;
        end else begin
            meas_new_q <= frame_end & frame_full;
            if (frame_end && frame_full) begin
                meas_q.cur <= 10'(sum_q[0] / 19'(NSAMP));
                meas_q.gf <= 10'(sum_q[1] / 19'(NSAMP));
                meas_q.volt <= 10'(sum_q[2] / 19'(NSAMP));
                meas_duty_q <= frame_duty_q;
            end
        end
    end

    // Steady state and full-conduction current from each new frame
    logic [9:0] cur_diff;
    assign cur_diff = (meas_q.cur > prev_cur_q) ? meas_q.cur - prev_cur_q
                                                : prev_cur_q - meas_q.cur;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev_cur_q <= 10'h000;
            prev_duty_q <= 4'h0;
            steady_q <= 1'b0;
            i_full_q <= 14'h0000;
            step_q <= 1'b0;
        end else begin
            step_q <= meas_new_q;
            if (meas_new_q) begin
                prev_cur_q <= meas_q.cur;
                prev_duty_q <= meas_duty_q;
                steady_q <= (cur_diff <= 10'(STEADY_TOL)) &&
                            (prev_duty_q == meas_duty_q);
                if (meas_duty_q != 4'h0) begin
                    i_full_q <= 14'((14'(meas_q.cur) * 14'h000A) /
                                    14'(meas_duty_q));
                end
            end
        end
    end

    // Estimated average current at the present and the next duty
    logic [17:0] est_now, est_next;
    assign est_now = (18'(i_full_q) * 18'(duty_q)) / 18'h0000A;
    assign est_next = (18'(i_full_q) * (18'(duty_q) + 18'h00001))
                      / 18'h0000A;

    // Duty command: drops at once to a lower target; power-limit drops and climbs go one step per steady frame
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            duty_q <= 4'h0;
        end else if (target == 4'h0) begin
            duty_q <= 4'h0;
        end else if (target < duty_q) begin
            duty_q <= target;
        end else if (step_q && steady_q) begin
            if (ctrl_q.plimit_en && est_now > 18'(plimit_q) &&
                duty_q != 4'h0) begin
                duty_q <= duty_q - 4'h1;
            end else if (duty_q < target && (!ctrl_q.plimit_en ||
                         (est_now < 18'(plimit_q) &&
                          est_next <= 18'(plimit_q)))) begin
                duty_q <= duty_q + 4'h1;
            end
        end
    end

    // Second and hour dividers for the tuning schedule
    logic [23:0] sec_cnt_q;
    logic [11:0] hour_cnt_q;
    logic sec_tick, hour_tick;
    assign sec_tick = (sec_cnt_q == SEC_LAST);
    assign hour_tick = sec_tick && (hour_cnt_q == HOUR_LAST);
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sec_cnt_q <= 24'h000000;
            hour_cnt_q <= 12'h000;
        end else begin
            sec_cnt_q <= sec_tick ? 24'h000000 : sec_cnt_q + 24'h000001;
            if (hour_tick) begin
                hour_cnt_q <= 12'h000;
            end else if (sec_tick) begin
                hour_cnt_q <= hour_cnt_q + 12'h001;
            end
        end
    end

    // Hourly mean absolute error; a reading on the hour starts the new sum
    logic [31:0] abs_sum_q, mean_err;
    logic [19:0] rd_cnt_q;
    logic dir_next;
    assign mean_err = (rd_cnt_q == 20'h00000) ? 32'h00000000
                    : abs_sum_q / 32'(rd_cnt_q);
    always_comb begin
        dir_next = dir_up_q;
        if (have_prev_q && mean_err[15:0] > hour_err_q) begin
            dir_next = ~dir_up_q;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            abs_sum_q <= 32'h00000000;
            rd_cnt_q <= 20'h00000;
            hour_err_q <= 16'h0000;
            have_prev_q <= 1'b0;
            dbf_q <= DBF_RESET;
            dir_up_q <= 1'b1;
        end else if (hour_tick) begin
            abs_sum_q <= temp_new_q ? 32'(abs_err) : 32'h00000000;
            rd_cnt_q <= temp_new_q ? 20'h00001 : 20'h00000;
            hour_err_q <= mean_err[15:0];
            have_prev_q <= 1'b1;
            // A bound turns the walk back so the factor keeps hunting
            if (dir_next && dbf_q == DBF_MAX) begin
                dbf_q <= dbf_q - 4'h1;
                dir_up_q <= 1'b0;
            end else if (!dir_next && dbf_q == DBF_MIN) begin
                dbf_q <= dbf_q + 4'h1;
                dir_up_q <= 1'b1;
            end else begin
                dbf_q <= dir_next ? dbf_q + 4'h1 : dbf_q - 4'h1;
                dir_up_q <= dir_next;
            end
        end else if (temp_new_q) begin
            abs_sum_q <= abs_sum_q + 32'(abs_err);
            rd_cnt_q <= rd_cnt_q + 20'h00001;
        end
    end

    // Register writes take effect in the access phase
    logic wr_en;
    assign wr_en = psel_i & penable_i & pwrite_i;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_q <= hcm_ctrl_t'(CTRL_RESET);
            setpoint_q <= SETPOINT_RESET;
            deadband_q <= DEADBAND_RESET;
            plimit_q <= PLIMIT_RESET;
            gain_q <= LIN_GAIN_RESET;
            offset_q <= LIN_OFFSET_RESET;
            curve_q <= LIN_CURVE_RESET;
        end else if (wr_en) begin
            if (paddr_i == OFS_CTRL) begin
                ctrl_q <= hcm_ctrl_t'(pwdata_i[3:0]);
            end else if (paddr_i == OFS_SETPOINT) begin
                setpoint_q <= pwdata_i[15:0];
            end else if (paddr_i == OFS_DEADBAND) begin
                deadband_q <= pwdata_i[7:0];
            end else if (paddr_i == OFS_PLIMIT) begin
                plimit_q <= pwdata_i[9:0];
            end else if (paddr_i == OFS_LIN_GAIN) begin
                gain_q <= pwdata_i[15:0];
            end else if (paddr_i == OFS_LIN_OFFSET) begin
                offset_q <= pwdata_i[15:0];
            end else if (paddr_i == OFS_LIN_CURVE) begin
                curve_q <= pwdata_i[15:0];
            end
        end
    end

    // Read mux; unmapped addresses read zero and flag an error
    logic [31:0] rdata_d;
    logic rerr_d;
    always_comb begin
        rdata_d = 32'h00000000;
        rerr_d = 1'b0;
        if (paddr_i == OFS_CTRL) begin
            rdata_d = {28'h0000000, ctrl_q};
        end else if (paddr_i == OFS_SETPOINT) begin
            rdata_d = {16'h0000, setpoint_q};
        end else if (paddr_i == OFS_DEADBAND) begin
            rdata_d = {24'h000000, deadband_q};
        end else if (paddr_i == OFS_PLIMIT) begin
            rdata_d = {22'h000000, plimit_q};
        end else if (paddr_i == OFS_LIN_GAIN) begin
            rdata_d = {16'h0000, gain_q};
        end else if (paddr_i == OFS_LIN_OFFSET) begin
            rdata_d = {16'h0000, offset_q};
        end else if (paddr_i == OFS_LIN_CURVE) begin
            rdata_d = {16'h0000, curve_q};
        end else if (paddr_i == OFS_STATUS) begin
            rdata_d = {15'h0000, dir_up_q, dbf_q, 1'b0, steady_q, gate_q,
                       demand_q, frame_duty_q, duty_q};
        end else if (paddr_i == OFS_TEMP) begin
            rdata_d = {16'h0000, temp_q};
        end else if (paddr_i == OFS_MEAS_CUR) begin
            rdata_d = {22'h000000, meas_q.cur};
        end else if (paddr_i == OFS_MEAS_GF) begin
            rdata_d = {22'h000000, meas_q.gf};
        end else if (paddr_i == OFS_MEAS_VOLT) begin
            rdata_d = {22'h000000, meas_q.volt};
        end else if (paddr_i == OFS_I_FULL) begin
            rdata_d = {18'h00000, i_full_q};
        end else if (paddr_i == OFS_HOUR_ERR) begin
            rdata_d = {16'h0000, hour_err_q};
        end else begin
            rerr_d = 1'b1;
        end
    end

    // Read data is captured in the setup phase so the slave needs no wait
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else if (psel_i && !penable_i) begin
            prdata_q <= pwrite_i ? 32'h00000000 : rdata_d;
            pslverr_q <= rerr_d;
        end
    end
    assign prdata_o = prdata_q;
    assign pslverr_o = pslverr_q & psel_i & penable_i;
    assign pready_o = 1'b1;
endmodule
`default_nettype wire

// [test/hcm_core_sva.sv]
// Port assertions for the heater modulation core
`default_nettype none
module hcm_core_chk (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic zero_cross_i,
    input wire logic heater_gate_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    logic unmapped;
    // Map ends at the last read-only word
    assign unmapped = paddr_i > 8'h34;
    sequence s_access;
        psel_i && !penable_i ##1 psel_i && penable_i;
    endsequence
    // Pin rise three or four edges back, after the synchroniser
    sequence s_zc_rise;
        ($past(zero_cross_i, 3) && !$past(zero_cross_i, 4)) ||
        ($past(zero_cross_i, 4) && !$past(zero_cross_i, 5));
    endsequence
    property p_gate_zc;
        $changed(heater_gate_o) |-> s_zc_rise;
    endproperty
    a_gate_zc: assert property (p_gate_zc)
        else $error("gate off crossing");
    property p_gate_rst;
        $rose(arst_n_i) |-> !heater_gate_o;
    endproperty
    a_gate_rst: assert property (p_gate_rst)
        else $error("gate after reset");
    property p_ready;
        pready_o;
    endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_err_phase;
        pslverr_o |-> psel_i && penable_i;
    endproperty
    a_err_phase: assert property (p_err_phase) else $error("stray pslverr");
    property p_err_unm;
        s_access ##0 unmapped |-> pslverr_o;
    endproperty
    a_err_unm: assert property (p_err_unm) else $error("no pslverr");
    property p_no_err;
        s_access ##0 (!unmapped && paddr_i[1:0] == 2'h0) |-> !pslverr_o;
    endproperty
    a_no_err: assert property (p_no_err) else $error("pslverr on map");
    property p_unm_zero;
        s_access ##0 (unmapped && !pwrite_i) |-> prdata_o == 32'h0;
    endproperty
    a_unm_zero: assert property (p_unm_zero) else $error("unmapped data");
    property p_rd_hold;
        s_access ##1 !psel_i |-> $stable(prdata_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("prdata moved");
endmodule
bind hcm_core hcm_core_chk i_chk (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .zero_cross_i(zero_cross_i),
    .heater_gate_o(heater_gate_o));
`default_nettype wire

// [test/hcm_line_model.sv]
// Line zero-cross and rectified heater measurement model
`default_nettype none
module hcm_line_model (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic gate_i,
    input wire logic [9:0] i_full_i,
    output logic zc_o,
    output logic adc_valid_o,
    output logic [1:0] adc_chan_o,
    output logic [9:0] adc_data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] ph_q;
    // Ninety clocks a power cycle: thirty samples per channel each
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ph_q <= 7'h00;
        end else begin
            ph_q <= (ph_q == 7'h59) ? 7'h00 : ph_q + 7'h01;
        end
    end
    assign zc_o = ph_q < 7'h05;
    assign adc_valid_o = arst_n_i;
    // Phase puts voltage, not current, on the edge that moves the gate
    assign adc_chan_o = 2'(ph_q % 7'h03);
    // Current follows the switch; ground fault and voltage steady
    always_comb begin
        case (adc_chan_o)
            2'h0: adc_data_o = gate_i ? i_full_i : 10'h000;
            2'h1: adc_data_o = 10'h00A;
            default: adc_data_o = 10'h1F4;
        endcase
    end
endmodule
`default_nettype wire

// [test/hcm_core_tb_top.sv]
// Self-checking bench for the heater modulation core
`default_nettype none
module hcm_core_tb_top;
    import hcm_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i = 1'b0, arst_n_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, r;
    logic pready_o, pslverr_o, zc, av, gate, ovr_i = 1'b1, tv = 1'b0;
    logic [1:0] ach;
    logic [9:0] ad;
    logic [11:0] traw = 12'h000;
    logic [64:0] exp_q[$], x; // Error, mask, masked value
    int mismatches = 0, n_tests = 0, cyc = 0;
    integer seed = 32'h177D;
    always #50 mclk_i = ~mclk_i;
    // Short hour of 3000 clocks so the factor walk shows within the run
    hcm_core #(.SEC_CYCLES_P(1000), .HOUR_SECONDS_P(3)) i_dut (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .zero_cross_i(zc),
        .override_closed_i(ovr_i), .adc_valid_i(av), .adc_chan_i(ach),
        .adc_data_i(ad), .temp_valid_i(tv), .temp_raw_i(traw),
        .heater_gate_o(gate));
    hcm_line_model i_line (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .gate_i(gate), .i_full_i(10'h190), .zc_o(zc), .adc_valid_o(av),
        .adc_chan_o(ach), .adc_data_o(ad));
    task automatic report_and_stop();
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Entered just after a rising edge; one idle cycle follows
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d, input logic [31:0] m, input logic e);
        if (!w) exp_q.push_back({e, m, d & m});
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        @(posedge mclk_i);
        while (pready_o !== 1'b1) @(posedge mclk_i);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
            input logic [31:0] m);
        apb(1'b0, a, d, m, 1'b0);
    endtask
    task automatic temp(input logic [11:0] v);
        traw <= v;
        tv <= 1'b1;
        @(posedge mclk_i);
        tv <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic frames(input int n);
        repeat (n * 900) @(posedge mclk_i);
    endtask
    // Read results compared against the oldest note; hang guard too
    always @(posedge mclk_i) begin
        cyc++;
        if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) begin
            n_tests++;
            x = exp_q.pop_front();
            if (((prdata_o & x[63:32]) !== x[31:0]) || pslverr_o !== x[64])
            begin
                mismatches++;
                $display("FAIL %0t rd %h got %h", $time, paddr_i, prdata_o);
            end
        end
        if (cyc > 70000) begin
            mismatches++;
            report_and_stop();
        end
    end
    initial begin
        repeat (2) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        @(posedge mclk_i);
        rd(OFS_CTRL, 32'h0, 32'hF);
        rd(OFS_PLIMIT, 32'h3FF, 32'h3FF);
        rd(OFS_LIN_GAIN, 32'h1000, 32'hFFFF);
        rd(OFS_STATUS, 32'h15000, 32'h1F000);
        apb(1'b0, 8'h40, 32'h0, 32'hFFFFFFFF, 1'b1);
        r = $random(seed);
        wr(OFS_SETPOINT, r);
        rd(OFS_SETPOINT, r, 32'hFFFF);
        wr(OFS_LIN_GAIN, 32'h2000);
        wr(OFS_LIN_OFFSET, 32'h5);
        temp(12'h03D);
        rd(OFS_TEMP, 32'h7F, 32'hFFFF);
        wr(OFS_LIN_GAIN, 32'h1000);
        wr(OFS_LIN_OFFSET, 32'h0);
        $display("test registers done");
        wr(OFS_SETPOINT, 32'h32);
        temp(12'h014);
        frames(3);
        rd(OFS_STATUS, 32'h100, 32'h100);
        temp(12'h050);
        frames(2);
        rd(OFS_STATUS, 32'h16000, 32'h1F3FF);
        wr(OFS_DEADBAND, 32'hA);
        temp(12'h037);
        frames(1);
        rd(OFS_STATUS, 32'h0, 32'h100);
        temp(12'h023);
        frames(1);
        rd(OFS_STATUS, 32'h17100, 32'h1F10E);
        rd(OFS_HOUR_ERR, 32'hA, 32'hFFFF);
        temp(12'h037);
        frames(1);
        rd(OFS_STATUS, 32'h100, 32'h100);
        temp(12'h03D);
        frames(1);
        rd(OFS_STATUS, 32'h0, 32'h100);
        $display("test on/off done");
        wr(OFS_CTRL, 32'h1);
        temp(12'h030);
        frames(20);
        rd(OFS_STATUS, 32'h22, 32'hFF);
        $display("test proportional done");
        wr(OFS_CTRL, 32'h2);
        wr(OFS_PLIMIT, 32'hD2);
        temp(12'h014);
        frames(12);
        rd(OFS_STATUS, 32'h55, 32'hFF);
        rd(OFS_MEAS_CUR, 32'hC8, 32'h3FF);
        rd(OFS_MEAS_GF, 32'hA, 32'h3FF);
        rd(OFS_MEAS_VOLT, 32'h1F4, 32'h3FF);
        rd(OFS_I_FULL, 32'h190, 32'h3FFF);
        wr(OFS_PLIMIT, 32'h82);
        frames(12);
        rd(OFS_STATUS, 32'h33, 32'hFF);
        wr(OFS_CTRL, 32'h6);
        ovr_i <= 1'b0;
        frames(2);
        rd(OFS_STATUS, 32'h0, 32'h200);
        $display("test power limit done");
        report_and_stop();
    end
endmodule
`default_nettype wire
